// >>> hw/strdesc_pkg.sv
// constants and carrier types for the string descriptor register bank
package strdesc_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  LANG_HIGH_ADDR   = 8'h21;
	localparam logic [7:0]  SER_LEN_ADDR     = 8'h22;
	localparam logic [7:0]  MKR_LEN_ADDR     = 8'h23;
	localparam logic [7:0]  SER_BASE         = 8'h30;
	localparam logic [7:0]  MKR_BASE         = 8'h50;

	// ----------------------------------------------------------------
	// array sizes and field widths
	// ----------------------------------------------------------------
	localparam int unsigned SER_DEPTH        = 32;
	localparam int unsigned MKR_DEPTH        = 64;
	localparam int unsigned DATA_W           = 8;
	localparam int unsigned SER_LEN_W        = 6;
	localparam int unsigned MKR_LEN_W        = 7;
	localparam int unsigned OFFSET_W         = 7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  LANG_HIGH_RST    = 8'h04;
	localparam logic [7:0]  LANG_LOW_DEFAULT = 8'h09;
	localparam logic [5:0]  SER_LEN_RST      = 6'h14;
	localparam logic [6:0]  MKR_LEN_RST      = 7'h00;

	// ----------------------------------------------------------------
	// string indices and fixed lengths
	// ----------------------------------------------------------------
	localparam logic [7:0]  IDX_LANG         = 8'h00;
	localparam logic [7:0]  IDX_SER          = 8'h01;
	localparam logic [7:0]  IDX_MKR          = 8'h03;
	localparam logic [6:0]  LANG_STR_LEN     = 7'h02;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} cfg_write_t;

	typedef struct packed
	{
		logic       valid;
		logic       present;
		logic [6:0] len;
		logic [7:0] data;
	} desc_answer_t;

	typedef enum logic
	{
		ST_LOAD = 1'b0,
		ST_RUN  = 1'b1
	} init_state_t;

endpackage

// >>> hw/strbyte_array.sv
// byte array of string data with one write port and two read ports
`timescale 1ns/10ps
module strbyte_array
#(
	parameter int unsigned DEPTH = 32,
	parameter int unsigned AW    = 5
)
(
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	// bulk initial load
	input  wire logic             init_we_i,
	input  wire logic [DEPTH*8-1:0] init_data_i,
	// byte write
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_idx_i,
	input  wire logic [7:0]       wr_data_i,
	// read ports
	input  wire logic [AW-1:0]    rd_a_idx_i,
	output logic      [7:0]       rd_a_data_o,
	input  wire logic [AW-1:0]    rd_b_idx_i,
	output logic      [7:0]       rd_b_data_o
);

	logic [7:0] mem [DEPTH];

	assign rd_a_data_o = mem[rd_a_idx_i];
	assign rd_b_data_o = mem[rd_b_idx_i];

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= 8'h00;
		end
		else if (init_we_i)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= init_data_i[i*8 +: 8];
		end
		else if (wr_en_i)
			mem[wr_idx_i] <= wr_data_i;
	end

endmodule

// >>> hw/strdesc_regs.sv
// string descriptor configuration registers and string byte fetch
`timescale 1ns/10ps
module strdesc_regs
	import strdesc_pkg::*;
#(
	parameter int unsigned SER_DEPTH_P   = SER_DEPTH,
	parameter int unsigned MKR_DEPTH_P   = MKR_DEPTH,
	parameter logic [7:0]  LANG_LOW_BYTE = LANG_LOW_DEFAULT
)
(
	// clock and reset
	input  wire logic                     clk_sys_i,
	input  wire logic                     rst_i,
	// configuration sources
	input  wire strdesc_pkg::cfg_write_t  host_wr_i,
	input  wire strdesc_pkg::cfg_write_t  ee_wr_i,
	input  wire logic                     custom_text_enable_i,
	input  wire logic                     custom_serial_enable_i,
	input  wire logic [SER_DEPTH_P*8-1:0] die_id_i,
	// register read back
	input  wire logic [7:0]               cfg_rd_addr_i,
	output logic      [7:0]               cfg_rdata_o,
	// string fetch
	input  wire logic                     desc_req_i,
	input  wire logic [7:0]               desc_index_i,
	input  wire logic [6:0]               desc_offset_i,
	output strdesc_pkg::desc_answer_t     desc_o,
	// field status
	output logic                          load_done_o,
	output logic      [7:0]               language_id_high_byte_o,
	output logic      [5:0]               serial_string_length_o,
	output logic      [6:0]               maker_string_length_o
);
	import strdesc_pkg::*;

	localparam int unsigned SER_AW = $clog2(SER_DEPTH_P);
	localparam int unsigned MKR_AW = $clog2(MKR_DEPTH_P);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic in_window(input logic [7:0] a,
		input logic [7:0] base, input int unsigned depth);
		return (int'(a) >= int'(base)) &&
			(int'(a) < int'(base) + int'(depth));
	endfunction

	function automatic logic [7:0] pad_ser(input logic [5:0] v);
		return {{(DATA_W - SER_LEN_W){1'b0}}, v};
	endfunction

	function automatic logic [7:0] pad_mkr(input logic [6:0] v);
		return {{(DATA_W - MKR_LEN_W){1'b0}}, v};
	endfunction

	// ----------------------------------------------------------------
	// state and fields
	// ----------------------------------------------------------------
	init_state_t  st;
	logic [7:0]   lang_high;
	logic [5:0]   ser_len;
	logic [6:0]   mkr_len;
	desc_answer_t desc_q;
	logic [7:0]   rdata_q;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	cfg_write_t        wreq;
	logic              take;
	logic              wr_lang;
	logic              wr_ser_len;
	logic              wr_mkr_len;
	logic              wr_ser_byte;
	logic              wr_mkr_byte;
	logic [7:0]        ser_wr_off;
	logic [7:0]        mkr_wr_off;

	// eeprom load wins a collision with a host write
	assign wreq        = ee_wr_i.we ? ee_wr_i : host_wr_i;
	// nothing is taken while fuse defaults are being placed
	assign take        = wreq.we && (st == ST_RUN);
	assign wr_lang     = take && (wreq.addr == LANG_HIGH_ADDR)
		&& custom_text_enable_i;
	assign wr_ser_len  = take && (wreq.addr == SER_LEN_ADDR);
	assign wr_mkr_len  = take && (wreq.addr == MKR_LEN_ADDR);
	assign wr_ser_byte = take && in_window(wreq.addr, SER_BASE,
		SER_DEPTH_P) && custom_serial_enable_i;
	assign wr_mkr_byte = take && in_window(wreq.addr, MKR_BASE,
		MKR_DEPTH_P);
	assign ser_wr_off  = wreq.addr - SER_BASE;
	assign mkr_wr_off  = wreq.addr - MKR_BASE;

	// ----------------------------------------------------------------
	// string storage
	// ----------------------------------------------------------------
	logic [7:0]        ser_rd_off;
	logic [7:0]        mkr_rd_off;
	logic [7:0]        ser_rd_a;
	logic [7:0]        ser_rd_b;
	logic [7:0]        mkr_rd_a;
	logic [7:0]        mkr_rd_b;

	assign ser_rd_off = cfg_rd_addr_i - SER_BASE;
	assign mkr_rd_off = cfg_rd_addr_i - MKR_BASE;

	// fuse die id is same-clock logic, taken in the load cycle
	strbyte_array #(.DEPTH(SER_DEPTH_P), .AW(SER_AW)) u_ser
	(
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.init_we_i   (st == ST_LOAD),
		.init_data_i (die_id_i),
		.wr_en_i     (wr_ser_byte),
		.wr_idx_i    (ser_wr_off[SER_AW-1:0]),
		.wr_data_i   (wreq.data),
		.rd_a_idx_i  (ser_rd_off[SER_AW-1:0]),
		.rd_a_data_o (ser_rd_a),
		.rd_b_idx_i  (desc_offset_i[SER_AW-1:0]),
		.rd_b_data_o (ser_rd_b)
	);

	strbyte_array #(.DEPTH(MKR_DEPTH_P), .AW(MKR_AW)) u_mkr
	(
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.init_we_i   (1'b0),
		.init_data_i ('0),
		.wr_en_i     (wr_mkr_byte),
		.wr_idx_i    (mkr_wr_off[MKR_AW-1:0]),
		.wr_data_i   (wreq.data),
		.rd_a_idx_i  (mkr_rd_off[MKR_AW-1:0]),
		.rd_a_data_o (mkr_rd_a),
		.rd_b_idx_i  (desc_offset_i[MKR_AW-1:0]),
		.rd_b_data_o (mkr_rd_b)
	);

	// ----------------------------------------------------------------
	// register read back
	// ----------------------------------------------------------------
	logic [7:0]        next_rdata;

	assign next_rdata =
		(cfg_rd_addr_i == LANG_HIGH_ADDR) ? lang_high :
		(cfg_rd_addr_i == SER_LEN_ADDR)   ? pad_ser(ser_len) :
		(cfg_rd_addr_i == MKR_LEN_ADDR)   ? pad_mkr(mkr_len) :
		in_window(cfg_rd_addr_i, SER_BASE, SER_DEPTH_P) ? ser_rd_a :
		in_window(cfg_rd_addr_i, MKR_BASE, MKR_DEPTH_P) ? mkr_rd_a :
		8'h00;

	// ----------------------------------------------------------------
	// string fetch
	// ----------------------------------------------------------------
	logic              is_lang;
	logic              is_ser;
	logic              is_mkr;
	logic [6:0]        sel_len;
	logic              in_str;
	logic              ser_fits;
	logic              mkr_fits;
	logic [7:0]        lang_byte;
	logic [7:0]        sel_byte;
	desc_answer_t      next_desc;

	assign is_lang   = desc_index_i == IDX_LANG;
	assign is_ser    = desc_index_i == IDX_SER;
	assign is_mkr    = desc_index_i == IDX_MKR;
	// a single language code, so index 0 always carries two bytes
	assign sel_len   = is_lang ? LANG_STR_LEN :
		is_ser ? {1'b0, ser_len} :
		is_mkr ? mkr_len : 7'h00;
	assign in_str    = desc_offset_i < sel_len;
	// a length beyond the array gives zero bytes, not wrapped data
	assign ser_fits  = int'(desc_offset_i) < int'(SER_DEPTH_P);
	assign mkr_fits  = int'(desc_offset_i) < int'(MKR_DEPTH_P);
	assign lang_byte = (desc_offset_i == 7'h00) ? LANG_LOW_BYTE :
		lang_high;
	assign sel_byte  = !in_str ? 8'h00 :
		is_lang ? lang_byte :
		is_ser  ? (ser_fits ? ser_rd_b : 8'h00) :
		(mkr_fits ? mkr_rd_b : 8'h00);
	assign next_desc.valid   = desc_req_i;
	assign next_desc.present = desc_req_i ? (sel_len != 7'h00) :
		desc_q.present;
	assign next_desc.len     = desc_req_i ? sel_len : desc_q.len;
	assign next_desc.data    = desc_req_i ? sel_byte : desc_q.data;

	// ----------------------------------------------------------------
	// flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st        <= ST_LOAD;
			lang_high <= LANG_HIGH_RST;
			ser_len   <= SER_LEN_RST;
			mkr_len   <= MKR_LEN_RST;
			rdata_q   <= 8'h00;
			desc_q    <= '0;
		end
		else
		begin
			st      <= ST_RUN;
			rdata_q <= next_rdata;
			desc_q  <= next_desc;
			if (wr_lang)
				lang_high <= wreq.data;
			if (wr_ser_len)
				ser_len <= wreq.data[SER_LEN_W-1:0];
			if (wr_mkr_len)
				mkr_len <= wreq.data[MKR_LEN_W-1:0];
		end
	end

	assign cfg_rdata_o             = rdata_q;
	assign desc_o                  = desc_q;
	assign load_done_o             = st == ST_RUN;
	assign language_id_high_byte_o = lang_high;
	assign serial_string_length_o  = ser_len;
	assign maker_string_length_o   = mkr_len;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_reset_values;
		@(posedge clk_sys_i) disable iff (rst_i)
		st == ST_LOAD |-> lang_high == 8'h04 && ser_len == 6'h14
			&& mkr_len == 7'h00;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("length or language field off its reset value");

	property p_lang_locked;
		@(posedge clk_sys_i) disable iff (rst_i)
		take && wreq.addr == LANG_HIGH_ADDR && !custom_text_enable_i
			|=> $stable(lang_high);
	endproperty
	a_lang_locked: assert property (p_lang_locked)
		else $error("language byte changed without custom strings");

	property p_lang_write;
		@(posedge clk_sys_i) disable iff (rst_i)
		take && wreq.addr == LANG_HIGH_ADDR && custom_text_enable_i
			|=> ##1 cfg_rdata_o == $past(wreq.data, 2)
			|| $past(cfg_rd_addr_i) != LANG_HIGH_ADDR;
	endproperty
	a_lang_write: assert property (p_lang_write)
		else $error("language byte read back differs from write");

	property p_ser_rsvd;
		@(posedge clk_sys_i) disable iff (rst_i)
		cfg_rd_addr_i == SER_LEN_ADDR |=> cfg_rdata_o[7:6] == 2'b00;
	endproperty
	a_ser_rsvd: assert property (p_ser_rsvd)
		else $error("serial length reserved bits not zero");

	property p_mkr_rsvd;
		@(posedge clk_sys_i) disable iff (rst_i)
		cfg_rd_addr_i == MKR_LEN_ADDR |=> cfg_rdata_o[7] == 1'b0;
	endproperty
	a_mkr_rsvd: assert property (p_mkr_rsvd)
		else $error("maker length reserved bit not zero");

	property p_ser_len_write;
		@(posedge clk_sys_i) disable iff (rst_i)
		take && wreq.addr == SER_LEN_ADDR
			|=> ser_len == $past(wreq.data[5:0]);
	endproperty
	a_ser_len_write: assert property (p_ser_len_write)
		else $error("serial length did not take the written value");

	property p_lang_one;
		@(posedge clk_sys_i) disable iff (rst_i)
		desc_req_i && is_lang |=> desc_o.valid && desc_o.len == 7'h02
			&& desc_o.present;
	endproperty
	a_lang_one: assert property (p_lang_one)
		else $error("index 0 does not report one language code");

	property p_ser_fetch;
		@(posedge clk_sys_i) disable iff (rst_i)
		desc_req_i && is_ser && ser_len != 6'h00
			|=> desc_o.valid && desc_o.len == {1'b0, $past(ser_len)};
	endproperty
	a_ser_fetch: assert property (p_ser_fetch)
		else $error("serial string length answered wrongly");

	property p_mkr_fetch;
		@(posedge clk_sys_i) disable iff (rst_i)
		desc_req_i && is_mkr && mkr_len != 7'h00
			|=> desc_o.present && desc_o.len == $past(mkr_len);
	endproperty
	a_mkr_fetch: assert property (p_mkr_fetch)
		else $error("maker string length answered wrongly");

	property p_past_end;
		@(posedge clk_sys_i) disable iff (rst_i)
		desc_req_i && desc_offset_i >= sel_len |=> desc_o.data == 8'h00;
	endproperty
	a_past_end: assert property (p_past_end)
		else $error("byte beyond string end not zero");

endmodule

// >>> testbench/cfg_source_model.sv
// configuration source standing in for an smbus host or eeprom loader
`timescale 1ns/10ps
module cfg_source_model
(
	// clock
	input  wire logic               clk_sys_i,
	// write strobe into the register bank
	output strdesc_pkg::cfg_write_t wr_o
);
	import strdesc_pkg::*;

	initial wr_o = '0;

	// a real agent never programs lengths past the byte arrays
	function automatic logic [7:0] legal(input logic [7:0] a,
		input logic [7:0] d);
		if (a == SER_LEN_ADDR && d[5:0] > 6'd32)
			return {d[7:6], 6'd32};
		if (a == MKR_LEN_ADDR && d[6:0] > 7'd64)
			return {d[7], 7'd64};
		return d;
	endfunction

	task automatic send(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		wr_o <= '{we: 1'b1, addr: a, data: legal(a, d)};
		@(negedge clk_sys_i);
		wr_o.we <= 1'b0;
	endtask

	// one character, low byte first
	task automatic put_char(input int n, input logic [15:0] c);
		send(MKR_BASE + 8'(2 * n), c[7:0]);
		send(MKR_BASE + 8'(2 * n + 1), c[15:8]);
	endtask
endmodule

// >>> testbench/strdesc_regs_test.sv
// self-checking bench for the string descriptor register bank
`timescale 1ns/10ps
module strdesc_regs_test;
	import strdesc_pkg::*;

	logic                   clk_sys_i;
	logic                   rst_i;
	logic                   text_en;
	logic                   ser_en;
	logic                   desc_req;
	logic                   load_done;
	cfg_write_t             host_wr;
	cfg_write_t             ee_wr;
	logic [SER_DEPTH*8-1:0] die_id;
	logic [7:0]             rd_addr;
	logic [7:0]             rdata;
	logic [7:0]             desc_index;
	logic [7:0]             lang_o;
	logic [6:0]             desc_offset;
	logic [6:0]             mkr_len_o;
	logic [5:0]             ser_len_o;
	desc_answer_t           desc;
	logic [31:0]            rnd;
	int                     fail_count;
	int                     checks;
	int                     cycles;
	int                     lang;
	int                     ser_len;
	int                     mkr_len;
	int                     ser_m[SER_DEPTH];
	int                     mkr_m[MKR_DEPTH];
	logic [7:0]             ser_tab[3] = '{8'he0, 8'hc1, 8'h0a};
	logic [7:0]             mkr_tab[2] = '{8'hc0, 8'h81};

	cfg_source_model host_src_inst (.clk_sys_i(clk_sys_i), .wr_o(host_wr));
	cfg_source_model ee_src_inst (.clk_sys_i(clk_sys_i), .wr_o(ee_wr));

	strdesc_regs #(.LANG_LOW_BYTE(LANG_LOW_DEFAULT)) strdesc_regs_inst
	(
		.clk_sys_i              (clk_sys_i),
		.rst_i                  (rst_i),
		.host_wr_i              (host_wr),
		.ee_wr_i                (ee_wr),
		.custom_text_enable_i   (text_en),
		.custom_serial_enable_i (ser_en),
		.die_id_i               (die_id),
		.cfg_rd_addr_i          (rd_addr),
		.cfg_rdata_o            (rdata),
		.desc_req_i             (desc_req),
		.desc_index_i           (desc_index),
		.desc_offset_i          (desc_offset),
		.desc_o                 (desc),
		.load_done_o            (load_done),
		.language_id_high_byte_o(lang_o),
		.serial_string_length_o (ser_len_o),
		.maker_string_length_o  (mkr_len_o)
	);

	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// whole run is well under a thousand cycles
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			end_of_test();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// reference copy of what an accepted write changes
	task automatic ref_write(input logic [7:0] a, input logic [7:0] d);
		if (a == LANG_HIGH_ADDR && text_en)
			lang = d;
		if (a == SER_LEN_ADDR)
			ser_len = d[5:0];
		if (a == MKR_LEN_ADDR)
			mkr_len = d[6:0];
		if (a >= SER_BASE && a < MKR_BASE && ser_en)
			ser_m[a - SER_BASE] = d;
		if (a >= MKR_BASE && a < 8'h90)
			mkr_m[a - MKR_BASE] = d;
	endtask

	task automatic wr(input bit ee, input logic [7:0] a, input logic [7:0] d);
		if (ee)
			ee_src_inst.send(a, d);
		else
			host_src_inst.send(a, d);
		ref_write(a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		int e;
		e = 0;
		if (a == LANG_HIGH_ADDR)
			e = lang;
		if (a == SER_LEN_ADDR)
			e = ser_len;
		if (a == MKR_LEN_ADDR)
			e = mkr_len;
		if (a >= SER_BASE && a < MKR_BASE)
			e = ser_m[a - SER_BASE];
		if (a >= MKR_BASE && a < 8'h90)
			e = mkr_m[a - MKR_BASE];
		@(negedge clk_sys_i);
		rd_addr = a;
		@(negedge clk_sys_i);
		check("rdata", rdata, 8'(e));
	endtask

	task automatic fetch(input logic [7:0] i, input int o);
		int n;
		int e;
		n = 0;
		e = 0;
		if (i == IDX_LANG)
			n = 2;
		else if (i == IDX_SER)
			n = ser_len;
		else if (i == IDX_MKR)
			n = mkr_len;
		if (o < n)
			e = (i == IDX_LANG) ? (o ? lang : LANG_LOW_DEFAULT) :
				(i == IDX_SER) ? ser_m[o] : mkr_m[o];
		@(negedge clk_sys_i);
		desc_req = 1'b1;
		desc_index = i;
		desc_offset = 7'(o);
		@(negedge clk_sys_i);
		desc_req = 1'b0;
		check("valid", {7'h0, desc.valid}, 8'h01);
		check("present", {7'h0, desc.present}, 8'(n != 0));
		check("len", {1'b0, desc.len}, 8'(n));
		check("data", desc.data, 8'(e));
	endtask

	initial
	begin
		rst_i = 1'b1;
		text_en = 1'b0;
		ser_en = 1'b0;
		desc_req = 1'b0;
		desc_index = 8'h00;
		desc_offset = 7'h00;
		rd_addr = 8'h00;
		rnd = 32'd80699;
		for (int n = 0; n < SER_DEPTH; n++)
		begin
			rnd = lfsr(rnd);
			die_id[8*n +: 8] = rnd[7:0];
			ser_m[n] = rnd[7:0];
		end
		for (int n = 0; n < MKR_DEPTH; n++)
			mkr_m[n] = 0;
		lang = 4;
		ser_len = 20;
		mkr_len = 0;
		repeat (10) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		check("load_done", {7'h0, load_done}, 8'h01);
		rd(LANG_HIGH_ADDR);
		rd(SER_LEN_ADDR);
		rd(MKR_LEN_ADDR);
		rd(8'h24);
		fetch(IDX_LANG, 0);
		fetch(IDX_LANG, 1);
		fetch(IDX_MKR, 0);
		fetch(8'h02, 0);
		$display("test reset values done");
		rnd = lfsr(rnd);
		wr(0, LANG_HIGH_ADDR, rnd[7:0]);
		rd(LANG_HIGH_ADDR);
		text_en = 1'b1;
		wr(1, LANG_HIGH_ADDR, rnd[15:8]);
		rd(LANG_HIGH_ADDR);
		fetch(IDX_LANG, 1);
		check("lang_o", lang_o, 8'(lang));
		$display("test language byte done");
		foreach (ser_tab[k])
		begin
			wr(k[0], SER_LEN_ADDR, ser_tab[k]);
			rd(SER_LEN_ADDR);
			check("ser_len_o", {2'b0, ser_len_o}, 8'(ser_len));
			fetch(IDX_SER, ser_len - 1);
			fetch(IDX_SER, ser_len);
		end
		foreach (mkr_tab[k])
		begin
			wr(k[0], MKR_LEN_ADDR, mkr_tab[k]);
			rd(MKR_LEN_ADDR);
			check("mkr_len_o", {1'b0, mkr_len_o}, 8'(mkr_len));
			fetch(IDX_MKR, mkr_len);
		end
		$display("test lengths done");
		rnd = lfsr(rnd);
		wr(0, SER_BASE, rnd[7:0]);
		ser_en = 1'b1;
		wr(1, SER_BASE + 8'h1f, rnd[15:8]);
		wr(0, SER_BASE + 8'h01, rnd[23:16]);
		wr(0, SER_LEN_ADDR, 8'h20);
		rd(SER_BASE);
		rd(SER_BASE + 8'h1f);
		for (int o = 0; o < SER_DEPTH; o++)
			fetch(IDX_SER, o);
		$display("test serial bytes done");
		for (int n = 0; n < 4; n++)
		begin
			rnd = lfsr(rnd);
			host_src_inst.put_char(n, rnd[15:0]);
			ref_write(MKR_BASE + 8'(2 * n), rnd[7:0]);
			ref_write(MKR_BASE + 8'(2 * n + 1), rnd[15:8]);
		end
		wr(1, MKR_LEN_ADDR, 8'h08);
		rd(MKR_BASE + 8'h07);
		for (int o = 0; o <= 8; o++)
			fetch(IDX_MKR, o);
		$display("test maker string done");
		fork
			host_src_inst.send(SER_LEN_ADDR, 8'h05);
			ee_src_inst.send(SER_LEN_ADDR, 8'h07);
		join
		ser_len = 7;
		rd(SER_LEN_ADDR);
		fetch(IDX_SER, 6);
		$display("test write collision done");
		// reset in mid-run: fields and bytes go back, fuses reload
		rst_i = 1'b1;
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		lang = 4;
		ser_len = 20;
		mkr_len = 0;
		for (int n = 0; n < MKR_DEPTH; n++)
			mkr_m[n] = 0;
		for (int n = 0; n < SER_DEPTH; n++)
			ser_m[n] = die_id[8*n +: 8];
		rd(LANG_HIGH_ADDR);
		rd(SER_LEN_ADDR);
		rd(MKR_LEN_ADDR);
		rd(SER_BASE + 8'h1f);
		rd(MKR_BASE + 8'h07);
		fetch(IDX_SER, 1);
		fetch(IDX_LANG, 1);
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule
